// ---- design/rce_chan_enable.sv ----
// Purpose: Receive channel enable logic: partition registers, channel
//          selection and bit-mask storage for a serial receiver.
// Assumes: Link clock, frame sync and data arrive from pins and are
//          sampled on the 10 MHz system clock.
// Notes:   Data is taken on rising link clock edges; frame sync high on
//          a rising edge marks the first bit of channel 0.
`timescale 1ns/1ps

module rce_chan_enable
  import rce_pkg::*;
#(
  parameter int FIFO_WORDS = rce_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] regIndex,
  input wire logic regWrite,
  input wire logic [rce_pkg::WORD_BITS-1:0] regWriteData,
  output logic [rce_pkg::WORD_BITS-1:0] regReadData,
  input wire logic rxMultichannelSelectOn,
  input wire logic rxChannelCountSelect,
  input wire logic [2:0] rxPartABlockField,
  input wire logic [2:0] rxPartBBlockField,
  input wire logic bitMaskMode,
  input wire logic [1:0] txMultichannelModeField,
  input wire logic rxLinkClockPin,
  input wire logic rxFrameSyncPin,
  input wire logic serialReceiveDataPin,
  input wire logic rxWordAck,
  output logic [rce_pkg::WORD_BITS-1:0] rxWord,
  output logic rxReady,
  output logic rxOverrun,
  output logic txEnableActive
);
  import rce_pkg::*;

  typedef enum logic {RX_IDLE, RX_SHIFT} rce_state_t;

  // ****************************************************************
  // Partition enable registers
  // ****************************************************************
  rce_parts_t parts_reg;
  logic [WORD_BITS-1:0] regReadData_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      parts_reg <= {NUM_PARTS{PART_RESET}};
    end else if (regWrite) begin
      parts_reg[regIndex] <= regWriteData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      regReadData_reg <= '0;
    end else begin
      regReadData_reg <= parts_reg[regIndex];
    end
  end

  assign regReadData = regReadData_reg;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Bit 0 link clock, bit 1 frame sync, bit 2 data. A level is accepted
  // only when stages two and three agree, which filters single glitches.
  wire [2:0] pinRaw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pinLevel_reg;
  wire [2:0] stableMask;
  wire [2:0] pinLevel_next;

  assign pinRaw = {serialReceiveDataPin, rxFrameSyncPin, rxLinkClockPin};
  assign stableMask = ~(sync2_reg ^ sync3_reg);
  assign pinLevel_next = (sync3_reg & stableMask) |
                         (pinLevel_reg & ~stableMask);

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pinLevel_reg <= '0;
    end else begin
      sync1_reg <= pinRaw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pinLevel_reg <= pinLevel_next;
    end
  end

  wire linkRise;
  wire frameLevel;
  wire dataLevel;

  assign linkRise = pinLevel_next[0] && !pinLevel_reg[0];
  assign frameLevel = pinLevel_next[1];
  assign dataLevel = pinLevel_next[2];

  // ****************************************************************
  // Serial word assembly
  // ****************************************************************
  rce_state_t state_reg;
  rce_state_t state_next;
  logic [3:0] bitCnt_reg;
  logic [3:0] bitCnt_next;
  logic [6:0] chan_reg;
  logic [6:0] chan_next;
  logic wordPhase_reg;
  logic wordPhase_next;
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] shift_next;

  wire frameStart;
  wire bitTaken;
  wire [3:0] bitPos;
  wire [6:0] wordChan;
  wire wordPhase;
  wire [WORD_BITS-1:0] maskPattern;
  wire maskBit;
  wire storedBit;
  wire wordDone;
  wire chanAccept;
  wire wordAccept;
  wire [WORD_BITS-1:0] wordValue;

  assign frameStart = linkRise && frameLevel;
  assign bitTaken = linkRise && (frameLevel || state_reg == RX_SHIFT);
  assign bitPos = frameStart ? 4'h0 : bitCnt_reg;
  assign wordChan = frameStart ? 7'h00 : chan_reg;
  assign wordPhase = frameStart ? 1'b0 : wordPhase_reg;

  // First arriving bit is the word's bit 15, so pattern bit 15 - pos rules it.
  assign maskPattern = wordPhase ? parts_reg[PART_B] : parts_reg[PART_A];
  assign maskBit = maskPattern[LAST_BIT - bitPos];
  assign storedBit = bitMaskMode ? (dataLevel & maskBit) : dataLevel;
  assign wordValue = {shift_reg[WORD_BITS-2:0], storedBit};
  assign wordDone = bitTaken && (bitPos == LAST_BIT);

  assign chanAccept = rce_chan_enabled(wordChan, parts_reg, rxChannelCountSelect,
                                       rxPartABlockField, rxPartBBlockField);
  // Bit-mask mode takes precedence: its word is stored, masked, whenever the FIFO has room.
  assign wordAccept = bitMaskMode || !rxMultichannelSelectOn || chanAccept;

  always_comb begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    chan_next = chan_reg;
    wordPhase_next = wordPhase_reg;
    shift_next = shift_reg;
    if (bitTaken) begin
      state_next = RX_SHIFT;
      bitCnt_next = bitPos + 4'h1;
      chan_next = wordChan;
      wordPhase_next = wordPhase;
      shift_next = wordValue;
      if (wordDone) begin
        chan_next = wordChan + 7'h01;
        wordPhase_next = !wordPhase;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= RX_IDLE;
      bitCnt_reg <= '0;
      chan_reg <= '0;
      wordPhase_reg <= 1'b0;
      shift_reg <= '0;
    end else begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      chan_reg <= chan_next;
      wordPhase_reg <= wordPhase_next;
      shift_reg <= shift_next;
    end
  end

  // ****************************************************************
  // FIFO push
  // ****************************************************************
  rce_fifo_if #(.WIDTH(WORD_BITS)) wordLink ();

  logic pushValid_reg;
  logic [WORD_BITS-1:0] pushData_reg;
  logic overrun_reg;
  wire pushNow;
  wire dropNow;

  // A full FIFO refuses the word; the loss is flagged rather than hidden.
  assign pushNow = wordDone && wordAccept && wordLink.wReady;
  assign dropNow = wordDone && wordAccept && !wordLink.wReady;

  always_ff @(posedge clock) begin
    if (rst) begin
      pushValid_reg <= 1'b0;
      pushData_reg <= '0;
      overrun_reg <= 1'b0;
    end else begin
      pushValid_reg <= pushNow;
      if (pushNow) begin
        pushData_reg <= wordValue;
      end
      overrun_reg <= overrun_reg || dropNow;
    end
  end

  assign wordLink.wData = pushData_reg;
  assign wordLink.wValid = pushValid_reg;

  rce_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .port(wordLink.fifo)
  );

  // ****************************************************************
  // Read-out stage
  // ****************************************************************
  logic [WORD_BITS-1:0] rxWord_reg;
  logic rxReady_reg;
  wire slotFree;
  wire takeWord;

  assign slotFree = !rxReady_reg || rxWordAck;
  assign takeWord = slotFree && wordLink.rValid;
  assign wordLink.rReady = takeWord;

  always_ff @(posedge clock) begin
    if (rst) begin
      rxWord_reg <= '0;
      rxReady_reg <= 1'b0;
    end else begin
      if (takeWord) begin
        rxWord_reg <= wordLink.rData;
      end
      if (slotFree) begin
        rxReady_reg <= wordLink.rValid;
      end
    end
  end

  assign rxWord = rxWord_reg;
  assign rxReady = rxReady_reg;
  assign rxOverrun = overrun_reg;

  // ****************************************************************
  // Transmit enable gate
  // ****************************************************************
  logic txEnableActive_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      txEnableActive_reg <= 1'b0;
    end else begin
      txEnableActive_reg <= (txMultichannelModeField != 2'h0) || bitMaskMode;
    end
  end

  assign txEnableActive = txEnableActive_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_wordKept;
    wordDone && wordAccept && wordLink.wReady;
  endsequence

  sequence s_pushOnce;
    pushValid_reg ##1 !pushValid_reg;
  endsequence

  property p_reset_clear;
    disable iff (1'b0) rst |=> (parts_reg == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Partition registers not cleared by reset.");

  property p_write_read;
    (regWrite && !rst) ##1 (!regWrite && $stable(regIndex)) |=> (regReadData == $past(regWriteData, 2));
  endproperty
  a_write_read: assert property (p_write_read) else $error("Written partition value not read back.");

  property p_count128;
    rxChannelCountSelect |-> (chanAccept == parts_reg[wordChan[6:4]][wordChan[3:0]]);
  endproperty
  a_count128: assert property (p_count128) else $error("Wrong enable bit for 128-channel mode.");

  property p_count32_unused;
    (!rxChannelCountSelect && wordChan[6:4] != rxPartABlockField &&
     wordChan[6:4] != rxPartBBlockField) |-> !chanAccept;
  endproperty
  a_count32_unused: assert property (p_count32_unused) else $error("Unassigned block accepted in 32-channel mode.");

  property p_count32_a;
    (!rxChannelCountSelect && wordChan[6:4] == rxPartABlockField) |->
      (chanAccept == parts_reg[PART_A][wordChan[3:0]]);
  endproperty
  a_count32_a: assert property (p_count32_a) else $error("Partition A block misrouted.");

  property p_disabled_dropped;
    (wordDone && rxMultichannelSelectOn && !bitMaskMode && !chanAccept) |=> !pushValid_reg;
  endproperty
  a_disabled_dropped: assert property (p_disabled_dropped) else $error("Disabled channel was stored.");

  property p_kept_pushed;
    s_wordKept |=> s_pushOnce;
  endproperty
  a_kept_pushed: assert property (p_kept_pushed) else $error("Accepted word not pushed once.");

  property p_mask_alternate;
    (wordDone && bitMaskMode) |=> (wordPhase_reg == !$past(wordPhase));
  endproperty
  a_mask_alternate: assert property (p_mask_alternate) else $error("Mask pattern did not alternate.");

  property p_mask_bit;
    (bitTaken && bitMaskMode) |->
      (storedBit == (dataLevel & maskPattern[4'hF - bitPos]));
  endproperty
  a_mask_bit: assert property (p_mask_bit) else $error("Bit-mask storage uses wrong enable bit.");

  property p_tx_gate;
    (txMultichannelModeField == 2'h0 && !bitMaskMode) [*2] |-> !txEnableActive;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("Transmit enables active while unused.");

endmodule // rce_chan_enable

// ---- design/rce_fifo.sv ----
// Purpose: Word FIFO between the serial receiver and the read-out stage.
// Assumes: DEPTH is a power of two.
// Notes:   Read data is shown from the head entry while rValid is high.
`timescale 1ns/1ps

module rce_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  rce_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  wire doWrite;
  wire doRead;
  wire isEmpty;
  wire isFull;

  assign isEmpty = (wrPtr_reg == rdPtr_reg);
  assign isFull = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                  (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign doWrite = port.wValid && !isFull;
  assign doRead = port.rReady && !isEmpty;
  assign port.wReady = !isFull;
  assign port.rValid = !isEmpty;
  assign port.rData = mem[rdPtr_reg[AW-1:0]];

  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_reg[AW-1:0]] <= port.wData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_reg + (AW+1)'(doWrite);
      rdPtr_reg <= rdPtr_reg + (AW+1)'(doRead);
    end
  end

endmodule // rce_fifo

// ---- design/rce_fifo_if.sv ----
// Purpose: Carries the word stream between the receiver and its FIFO.
// Assumes: One clock domain shared by both ends.
// Notes:   Valid and ready on both sides.
`timescale 1ns/1ps

interface rce_fifo_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] wData;
  logic wValid;
  logic wReady;
  logic [WIDTH-1:0] rData;
  logic rValid;
  logic rReady;

  modport fifo (input wData, input wValid, output wReady,
                output rData, output rValid, input rReady);
  modport user (output wData, output wValid, input wReady,
                input rData, input rValid, output rReady);
endinterface

// ---- design/rce_pkg.sv ----
// Purpose: Shared constants, types and channel decode for the receive
//          channel enable block.
// Assumes: Sixteen-bit words and eight partitions of sixteen channels.
// Notes:   Functional notes follow below.

package rce_pkg;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int WORD_BITS = 16;
  localparam int NUM_PARTS = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 3;
  localparam logic [15:0] PART_RESET = 16'h0000;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [2:0] PART_A = 3'h0;
  localparam logic [2:0] PART_B = 3'h1;
  localparam int CLK_PERIOD_NS = 100;

  typedef logic [NUM_PARTS-1:0][WORD_BITS-1:0] rce_parts_t;

  // ****************************************************************
  // Channel decode
  // ****************************************************************
  function automatic logic rce_chan_enabled(input logic [6:0] chan,
                                            input rce_parts_t parts,
                                            input logic countSel,
                                            input logic [2:0] blkA,
                                            input logic [2:0] blkB);
    logic en;
    en = 1'b0;
    if (countSel) begin
      en = parts[chan[6:4]][chan[3:0]];
    end else if (chan[6:4] == blkA) begin
      en = parts[PART_A][chan[3:0]];
    end else if (chan[6:4] == blkB) begin
      en = parts[PART_B][chan[3:0]];
    end
    return en;
  endfunction

endpackage

// ---- tb/rce_framer_model.sv ----
// Purpose: Behavioural serial framer driving link clock, frame sync and data pins.
// Assumes: An 800 ns link period; the link clock stands low outside frames.
// Notes:   Word i of a frame carries base + i and is shifted out most significant bit first.
`timescale 1ns/1ps

module rce_framer_model (
  output logic linkClk,
  output logic frameSync,
  output logic dataOut
);
  localparam int HALF_NS = 400;

  initial begin
    linkClk = 1'b0;
    frameSync = 1'b0;
    dataOut = 1'b0;
  end

  // ****************************************************************
  // Frame transmission
  // ****************************************************************
  // The odd start offset keeps link edges out of phase with the system clock.
  // After a frame the data line shows the inverse of its last bit, so a stale level never passes for data.
  task automatic send_frame(input int n, input logic [15:0] base);
    logic [15:0] w;
    #37;
    for (int i = 0; i < n; i++) begin
      w = base + 16'(i);
      for (int b = 15; b >= 0; b--) begin
        dataOut = w[b];
        frameSync = (i == 0) && (b == 15);
        #HALF_NS linkClk = 1'b1;
        #HALF_NS linkClk = 1'b0;
      end
    end
    frameSync = 1'b0;
    dataOut = ~dataOut;
  endtask
endmodule // rce_framer_model

// ---- tb/tb_rce_chan_enable.sv ----
// Purpose: Self-checking bench for the receive channel enable block.
// Assumes: Inputs change on the falling clock edge; the framer model drives the pins.
// Notes:   Each frame is sent whole before its words are drained and compared.
`timescale 1ns/1ps

module tb_rce_chan_enable;
  import rce_pkg::*;

  localparam int MAX_CYCLES = 40000;

  logic clock;
  logic rst;
  logic [2:0] regIndex;
  logic regWrite;
  logic [15:0] regWriteData;
  logic [15:0] regReadData;
  logic rxMultichannelSelectOn;
  logic rxChannelCountSelect;
  logic [2:0] rxPartABlockField;
  logic [2:0] rxPartBBlockField;
  logic bitMaskMode;
  logic [1:0] txMultichannelModeField;
  logic rxLinkClockPin;
  logic rxFrameSyncPin;
  logic serialReceiveDataPin;
  logic rxWordAck;
  logic [15:0] rxWord;
  logic rxReady;
  logic rxOverrun;
  logic txEnableActive;
  int n_errors;
  int check_count;
  int cycles;
  logic [15:0] expQ[$];
  logic [15:0] rd;
  logic [15:0] mA;
  logic [15:0] mB;

  rce_chan_enable #(.FIFO_WORDS(16)) rce_chan_enable_inst (
    .clock(clock),
    .rst(rst),
    .regIndex(regIndex),
    .regWrite(regWrite),
    .regWriteData(regWriteData),
    .regReadData(regReadData),
    .rxMultichannelSelectOn(rxMultichannelSelectOn),
    .rxChannelCountSelect(rxChannelCountSelect),
    .rxPartABlockField(rxPartABlockField),
    .rxPartBBlockField(rxPartBBlockField),
    .bitMaskMode(bitMaskMode),
    .txMultichannelModeField(txMultichannelModeField),
    .rxLinkClockPin(rxLinkClockPin),
    .rxFrameSyncPin(rxFrameSyncPin),
    .serialReceiveDataPin(serialReceiveDataPin),
    .rxWordAck(rxWordAck),
    .rxWord(rxWord),
    .rxReady(rxReady),
    .rxOverrun(rxOverrun),
    .txEnableActive(txEnableActive)
  );

  rce_framer_model rce_framer_model_inst (
    .linkClk(rxLinkClockPin),
    .frameSync(rxFrameSyncPin),
    .dataOut(serialReceiveDataPin)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic write_reg(input logic [2:0] idx, input logic [15:0] d);
    @(negedge clock);
    regIndex = idx;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask

  task automatic read_reg(input logic [2:0] idx, output logic [15:0] d);
    @(negedge clock);
    regIndex = idx;
    repeat (2) @(negedge clock);
    d = regReadData;
  endtask

  // A missing word is compared against the inverse of its expectation so it always counts as a mismatch.
  // One idle edge between acknowledges keeps the strobe from falling and rising in one time step.
  task automatic drain_expect();
    int t;
    logic [15:0] e;
    repeat (10) @(negedge clock);
    while (expQ.size() > 0) begin
      e = expQ.pop_front();
      t = 0;
      while (rxReady !== 1'b1 && t < 50) begin
        @(negedge clock);
        t++;
      end
      check((rxReady === 1'b1) ? rxWord : ~e, e);
      rxWordAck = 1'b1;
      @(negedge clock);
      rxWordAck = 1'b0;
      @(negedge clock);
    end
    repeat (3) @(negedge clock);
    check({15'h0, rxReady}, 16'h0000);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      n_errors++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    regIndex = 3'h0;
    regWrite = 1'b0;
    regWriteData = 16'h0000;
    rxMultichannelSelectOn = 1'b0;
    rxChannelCountSelect = 1'b0;
    rxPartABlockField = 3'h0;
    rxPartBBlockField = 3'h0;
    bitMaskMode = 1'b0;
    txMultichannelModeField = 2'h0;
    rxWordAck = 1'b0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    for (int k = 0; k < 8; k++) begin
      read_reg(3'(k), rd);
      check(rd, 16'h0000);
    end
    for (int k = 0; k < 8; k++) write_reg(3'(k), 16'h1111 * 16'(k + 1));
    for (int k = 0; k < 8; k++) begin
      read_reg(3'(k), rd);
      check(rd, 16'h1111 * 16'(k + 1));
    end
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      @(negedge clock);
      txMultichannelModeField = 2'(m);
      bitMaskMode = m[2];
      repeat (2) @(negedge clock);
      check({15'h0, txEnableActive}, {15'h0, (m[1:0] != 2'h0) || m[2]});
    end
    txMultichannelModeField = 2'h0;
    $display("test transmit enable done");
    // Multichannel stays on here: bit-mask mode must win and keep every word.
    mA = 16'hF0F0;
    mB = 16'h0F3C;
    write_reg(PART_A, mA);
    write_reg(PART_B, mB);
    bitMaskMode = 1'b1;
    rxMultichannelSelectOn = 1'b1;
    rce_framer_model_inst.send_frame(3, 16'hABCD);
    rce_framer_model_inst.send_frame(2, 16'h1234);
    for (int i = 0; i < 3; i++) expQ.push_back((16'hABCD + 16'(i)) & ((i % 2 == 0) ? mA : mB));
    for (int i = 0; i < 2; i++) expQ.push_back((16'h1234 + 16'(i)) & ((i % 2 == 0) ? mA : mB));
    drain_expect();
    $display("test bit mask done");
    bitMaskMode = 1'b0;
    rxPartABlockField = 3'h1;
    write_reg(PART_A, 16'h0005);
    write_reg(PART_B, 16'h8001);
    write_reg(3'h2, 16'hFFFF);
    rce_framer_model_inst.send_frame(48, 16'h5A00);
    expQ = '{16'h5A00, 16'h5A0F, 16'h5A10, 16'h5A12};
    drain_expect();
    $display("test 32 channels done");
    rxChannelCountSelect = 1'b1;
    for (int k = 0; k < 8; k++) write_reg(3'(k), 16'h0001 << k);
    write_reg(3'h7, 16'h8080);
    rce_framer_model_inst.send_frame(128, 16'h6000);
    for (int k = 0; k < 8; k++) expQ.push_back(16'h6000 + 16'(17 * k));
    expQ.push_back(16'h607F);
    drain_expect();
    $display("test 128 channels done");
    check({15'h0, rxOverrun}, 16'h0000);
    rxMultichannelSelectOn = 1'b0;
    rxChannelCountSelect = 1'b0;
    rce_framer_model_inst.send_frame(20, 16'h7100);
    repeat (10) @(negedge clock);
    check({15'h0, rxOverrun}, 16'h0001);
    // The read-out register holds one word beyond the sixteen in the FIFO, so seventeen survive.
    for (int i = 0; i < 17; i++) expQ.push_back(16'h7100 + 16'(i));
    drain_expect();
    $display("test buffer full done");
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check({15'h0, rxOverrun}, 16'h0000);
    read_reg(3'h7, rd);
    check(rd, 16'h0000);
    $display("test second reset done");
    wrap_up();
  end
endmodule // tb_rce_chan_enable
